// ===== core/pdc_device.sv
// module: digital control side of the phase locked loop
// ****************************************
// What this block does
// RULE1 - one phase step per toggle of input
// RULE2 - two-bit select picks adjusted output
// RULE3 - direction input chooses advance or retard
// RULE4 - lock high while locked, asynchronous to consumers
// RULE5 - phase step on feedback output drops lock
// RULE6 - bus rewrite drops lock until lock time
// RULE7 - settings changeable at run time over bus
// RULE8 - phase fixed at configuration or dynamic
// RULE9 - reference switchable between two sources live
// RULE10 - loop reset keeps input divider
// RULE11 - second loop reset clears input divider
// RULE12 - third divider reset touches only third
// RULE13 - fourth divider reset touches only fourth
// RULE14 - each output runs only when enabled
// RULE15 - standby powers the loop down
// RULE16 - status shows phase source pins or bus
// RULE17 - bus reset clears only bus logic
// RULE18 - bus runs on its own clock
// RULE19 - five-bit bus address
// RULE20 - eight-bit bus write data
// RULE21 - separate eight-bit read data
// RULE22 - strobe marks transfer, write enable direction
// RULE23 - acknowledge answers every strobed transfer
// RULE24 - master holds request until acknowledge
// ****************************************
`timescale 1ns/10ps
module pdc_device
    import pdc_pkg::*;
#(
    parameter logic [7:0] INIT_PHASE = 8'h00
) (
    input  wire logic clk,
    input  wire logic rst_n,
    pdc_if.device     pins
);
    // ****************************************
    // model of the loop timing, kept digital
    // ****************************************
    logic [7:0]         settings [NUM_LOC];
    logic [2:0]         tog_sync;
    logic [1:0]         ref_sync;
    logic [LOCK_W-1:0]  lock_cnt;
    logic               lock_q;
    logic [PHASE_W-1:0] phase [NUM_OUT];
    logic [7:0]         in_div_cnt;
    logic [7:0]         fb_div_cnt;
    logic [1:0]         out_div [NUM_OUT];
    logic [NUM_OUT-1:0] out_q;
    logic               ref_sel;
    logic               loop_rst_any;
    logic               step_evt;
    logic               src_bus;
    logic               lock_lost;
    logic               ack_q;
    logic [7:0]         rdata_q;
    logic               bus_wr_evt;
    logic [1:0]         bw_sync;
    logic               bw_tog;
    logic               bw_seen;

    assign src_bus      = settings[LOC_CTRL][CTRL_PHASE_SRC];
    assign loop_rst_any = pins.loop_reset | pins.loop_reset_with_input_divider | pins.standby_power_down; // RULE10 RULE11 RULE15
    assign step_evt     = (tog_sync[2] ^ tog_sync[1]) & ~src_bus; // RULE1 RULE8
    assign bus_wr_evt   = bw_sync[1] ^ bw_seen;
    assign lock_lost    = loop_rst_any | bus_wr_evt | (step_evt & pins.phase_output_select == 2'b00); // RULE5 RULE6
    assign ref_sel      = ref_sync[1] ^ settings[LOC_CTRL][CTRL_REF_SEL]; // RULE9

    always_ff @(posedge clk) begin
        tog_sync <= {tog_sync[1:0], pins.phase_step_toggle};
        ref_sync <= {ref_sync[0], pins.reference_source_switch};
        bw_sync  <= {bw_sync[0], bw_tog};
        bw_seen  <= bw_sync[1];
    end

    // ****************************************
    // lock counter
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rst_n || lock_lost) begin
            lock_cnt <= '0;
            lock_q   <= 1'b0;
        end else if (lock_cnt == LOCK_W'(LOCK_CYCLES - 1)) begin
            lock_q <= 1'b1; // RULE4
        end else begin
            lock_cnt <= lock_cnt + 1'b1;
        end
    end
    assign pins.lock = lock_q;
    assign pins.phase_control_source = src_bus; // RULE16

    // ****************************************
    // phase and dividers
    // ****************************************
    genvar g;
    generate
        for (g = 0; g < NUM_OUT; g++) begin : g_out
            logic div_rst;
            assign div_rst = loop_rst_any | (g == 2 && pins.third_output_divider_reset) // RULE12
                           | (g == 3 && pins.fourth_output_divider_reset); // RULE13
            always_ff @(posedge clk) begin
                if (!rst_n) begin
                    phase[g] <= INIT_PHASE; // RULE8
                end else if (src_bus && bus_wr_evt) begin
                    phase[g] <= settings[LOC_PHASE]; // RULE7
                end else if (step_evt && pins.phase_output_select == 2'(g)) begin // RULE2
                    phase[g] <= pins.phase_direction ? phase[g] + 1'b1 : phase[g] - 1'b1; // RULE3
                end
            end
            always_ff @(posedge clk) begin
                if (!rst_n || div_rst) begin
                    out_div[g] <= '0;
                    out_q[g]   <= 1'b0;
                end else if (pins.output_enable[g] && lock_q) begin // RULE14
                    out_div[g] <= out_div[g] + 1'b1;
                    out_q[g]   <= out_div[g][1] ^ phase[g][0];
                end else begin
                    out_q[g] <= 1'b0; // RULE14
                end
            end
        end
    endgenerate
    assign pins.output_clock = out_q;

    // input divider keeps count across the plain loop reset
    always_ff @(posedge clk) begin
        if (!rst_n || pins.loop_reset_with_input_divider) begin // RULE11
            in_div_cnt <= '0;
        end else if (!pins.standby_power_down) begin // RULE10 RULE15
            in_div_cnt <= in_div_cnt + {7'h00, ref_sel};
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n || loop_rst_any) begin
            fb_div_cnt <= '0;
        end else begin
            fb_div_cnt <= (fb_div_cnt >= settings[LOC_DIV_FB]) ? 8'h00 : fb_div_cnt + 8'h01;
        end
    end

    // ****************************************
    // configuration bus, on its own clock
    // ****************************************
    // bus reset clears handshake, read data and write toggle; system reset loads the three used locations of the setting store
    always_ff @(posedge pins.cfg_bus_clock) begin // RULE18
        if (pins.cfg_bus_reset) begin // RULE17
            ack_q   <= 1'b0;
            rdata_q <= 8'h00;
            bw_tog  <= 1'b0;
        end else begin
            ack_q <= pins.cfg_bus_strobe & ~ack_q; // RULE22 RULE23 RULE24
            if (pins.cfg_bus_strobe && !ack_q) begin
                if (pins.cfg_bus_write_enable && pins.cfg_bus_address != LOC_STATUS) begin // RULE19 RULE20
                    bw_tog <= ~bw_tog; // RULE6 RULE7
                end
                rdata_q <= (pins.cfg_bus_address == LOC_STATUS) ? {6'h00, src_bus, lock_q}
                                                                : settings[pins.cfg_bus_address]; // RULE21
            end
        end
    end
    // system reset loads the used locations; bus reset leaves them alone
    always_ff @(posedge pins.cfg_bus_clock) begin
        if (!rst_n) begin
            settings[LOC_CTRL]   <= CTRL_RESET;
            settings[LOC_PHASE]  <= PHASE_RESET;
            settings[LOC_DIV_FB] <= DIV_RESET;
        end else if (pins.cfg_bus_strobe && !ack_q && pins.cfg_bus_write_enable) begin
            settings[pins.cfg_bus_address] <= pins.cfg_bus_write_data; // RULE7 RULE17
        end
    end
    assign pins.cfg_bus_acknowledge = ack_q;
    assign pins.cfg_bus_read_data   = rdata_q;
endmodule

// ===== core/pdc_pkg.sv
// package: shared constants for the loop control block and its user logic
package pdc_pkg;
    localparam int ADDR_W = 5;
    localparam int DATA_W = 8;
    localparam int NUM_OUT = 4;
    localparam int NUM_LOC = 32;
    // location map of the setting store
    localparam logic [4:0] LOC_CTRL = 5'h00;
    localparam logic [4:0] LOC_PHASE = 5'h01;
    localparam logic [4:0] LOC_DIV_FB = 5'h02;
    localparam logic [4:0] LOC_STATUS = 5'h1F;
    // control location fields
    localparam int CTRL_PHASE_SRC = 0;
    localparam int CTRL_REF_SEL = 1;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] PHASE_RESET = 8'h00;
    localparam logic [7:0] DIV_RESET = 8'h04;
    // lock_acquire_time, held as a count of clk cycles
    localparam int LOCK_TIME_US = 50;
    localparam int CLK_MHZ = 20;
    localparam int LOCK_CYCLES = LOCK_TIME_US * CLK_MHZ;
    localparam int LOCK_W = 11;
    localparam int PHASE_W = 8;
    // user side command offsets
    localparam logic [3:0] UR_CMD = 4'h0;
    localparam logic [3:0] UR_ADDR = 4'h1;
    localparam logic [3:0] UR_WDATA = 4'h2;
    localparam logic [3:0] UR_CTRL = 4'h3;
    localparam logic [3:0] UR_STATUS = 4'h4;
    localparam logic [3:0] UR_RDATA = 4'h5;
    localparam int CMD_STEP = 0;
    localparam int CMD_BUSW = 1;
    localparam int CMD_BUSR = 2;
endpackage

// ===== core/pdc_if.sv
// interface: pins between the loop control block and the user logic
`timescale 1ns/10ps
interface pdc_if;
    logic       reference_clock_in;
    logic       feedback_clock_in;
    logic [1:0] phase_output_select;
    logic       phase_direction;
    logic       phase_step_toggle;
    logic       lock;
    logic       phase_control_source;
    logic       standby_power_down;
    logic       loop_reset;
    logic       loop_reset_with_input_divider;
    logic       third_output_divider_reset;
    logic       fourth_output_divider_reset;
    logic [3:0] output_enable;
    logic [3:0] output_clock;
    logic       reference_source_switch;
    logic       cfg_bus_clock;
    logic       cfg_bus_reset;
    logic       cfg_bus_strobe;
    logic       cfg_bus_write_enable;
    logic [4:0] cfg_bus_address;
    logic [7:0] cfg_bus_write_data;
    logic [7:0] cfg_bus_read_data;
    logic       cfg_bus_acknowledge;
    modport device (
        input  reference_clock_in, feedback_clock_in, phase_output_select, phase_direction,
        input  phase_step_toggle, standby_power_down, loop_reset, loop_reset_with_input_divider,
        input  third_output_divider_reset, fourth_output_divider_reset, output_enable,
        input  reference_source_switch, cfg_bus_clock, cfg_bus_reset, cfg_bus_strobe,
        input  cfg_bus_write_enable, cfg_bus_address, cfg_bus_write_data,
        output lock, phase_control_source, output_clock, cfg_bus_read_data, cfg_bus_acknowledge
    );
    modport user (
        output reference_clock_in, feedback_clock_in, phase_output_select, phase_direction,
        output phase_step_toggle, standby_power_down, loop_reset, loop_reset_with_input_divider,
        output third_output_divider_reset, fourth_output_divider_reset, output_enable,
        output reference_source_switch, cfg_bus_clock, cfg_bus_reset, cfg_bus_strobe,
        output cfg_bus_write_enable, cfg_bus_address, cfg_bus_write_data,
        input  lock, phase_control_source, output_clock, cfg_bus_read_data, cfg_bus_acknowledge
    );
endinterface

// ===== core/pdc_user.sv
// module: user logic end driving the loop control pins and config bus
`timescale 1ns/10ps
module pdc_user
    import pdc_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [3:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic [7:0]      rdata,
    pdc_if.user             pins
);
    typedef enum logic [1:0] {PDC_IDLE, PDC_REQ, PDC_DROP} pdc_bus_e;
    pdc_bus_e   state;
    pdc_bus_e   next_state;
    logic [7:0] ctrl;
    logic [4:0] b_addr;
    logic [7:0] b_wdata;
    logic [7:0] b_rdata;
    logic       b_we;
    logic       tog;
    logic       div_q;
    logic [1:0] lock_s;
    logic [1:0] ack_s;
    logic [1:0] src_s;
    logic       cmd_wr;
    logic       busy;

    assign cmd_wr = wr && addr == UR_CMD;
    assign busy   = state != PDC_IDLE;

    // ****************************************
    // software port
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl    <= 8'h00;
            b_addr  <= 5'h00;
            b_wdata <= 8'h00;
            tog     <= 1'b0;
            rdata   <= 8'h00;
        end else begin
            if (wr && addr == UR_CTRL) ctrl <= wdata;
            if (wr && addr == UR_ADDR) b_addr <= wdata[4:0]; // RULE19
            if (wr && addr == UR_WDATA) b_wdata <= wdata; // RULE20
            if (cmd_wr && wdata[CMD_STEP]) tog <= ~tog; // RULE1
            rdata <= !rd ? 8'h00 : addr == UR_CTRL ? ctrl : addr == UR_ADDR ? {3'h0, b_addr}
                   : addr == UR_WDATA ? b_wdata : addr == UR_RDATA ? b_rdata
                   : addr == UR_STATUS ? {5'h00, busy, src_s[1], lock_s[1]} : 8'h00; // RULE4 RULE5 RULE6
        end
    end

    // sync the asynchronous device outputs before use
    always_ff @(posedge clk) begin
        lock_s <= {lock_s[0], pins.lock}; // RULE4
        ack_s  <= {ack_s[0], pins.cfg_bus_acknowledge};
        src_s  <= {src_s[0], pins.phase_control_source};
    end

    // ****************************************
    // config bus master, clock made by divider
    // ****************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state <= PDC_IDLE;
            b_we  <= 1'b0;
            b_rdata <= 8'h00;
        end else begin
            state <= next_state;
            if (state == PDC_IDLE && cmd_wr) b_we <= wdata[CMD_BUSW]; // RULE22
            if (state == PDC_REQ && ack_s[1]) b_rdata <= pins.cfg_bus_read_data;
        end
    end

    // bus clock runs through reset, else the bus reset never reaches an edge
    always_ff @(posedge clk) begin
        if (div_q) begin
            div_q <= 1'b0;
        end else begin
            div_q <= 1'b1; // RULE18
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            PDC_IDLE: if (cmd_wr && (wdata[CMD_BUSW] || wdata[CMD_BUSR])) next_state = PDC_REQ;
            PDC_REQ:  if (ack_s[1]) next_state = PDC_DROP; // RULE24
            PDC_DROP: if (!ack_s[1]) next_state = PDC_IDLE; // RULE24
            default:  next_state = PDC_IDLE;
        endcase
    end

    assign pins.cfg_bus_clock        = div_q;
    assign pins.cfg_bus_reset        = ~rst_n;
    assign pins.cfg_bus_strobe       = state == PDC_REQ; // RULE22 RULE23
    assign pins.cfg_bus_write_enable = b_we;
    assign pins.cfg_bus_address      = b_addr;
    assign pins.cfg_bus_write_data   = b_wdata;
    assign pins.phase_step_toggle    = tog;
    assign pins.phase_direction      = ctrl[0];
    assign pins.phase_output_select  = ctrl[2:1];
    assign pins.standby_power_down   = ctrl[3];
    assign pins.loop_reset           = ctrl[4];
    assign pins.loop_reset_with_input_divider = ctrl[5];
    assign pins.third_output_divider_reset    = ctrl[6];
    assign pins.fourth_output_divider_reset   = ctrl[7];
    assign pins.output_enable        = 4'hF;
    assign pins.reference_source_switch = 1'b0;
    assign pins.reference_clock_in   = clk;
    assign pins.feedback_clock_in    = pins.output_clock[0];
endmodule

// ===== verification/pdc_properties.sv
// checker: properties of the pins between the two ends
`timescale 1ns/10ps
module pdc_properties
    import pdc_pkg::*;
(
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic [1:0] phase_output_select,
    input wire logic       phase_step_toggle,
    input wire logic       phase_control_source,
    input wire logic       lock,
    input wire logic       standby_power_down,
    input wire logic       loop_reset,
    input wire logic       loop_reset_with_input_divider,
    input wire logic       cfg_bus_clock,
    input wire logic       cfg_bus_reset,
    input wire logic       cfg_bus_strobe,
    input wire logic       cfg_bus_write_enable,
    input wire logic [4:0] cfg_bus_address,
    input wire logic [7:0] cfg_bus_write_data,
    input wire logic       cfg_bus_acknowledge
);
    // ****************************************
    // lock wait counter and properties
    // ****************************************
    // saturates, so a long standby cannot wrap it
    logic [10:0] low_cnt;
    always_ff @(posedge clk) begin
        if (!rst_n || lock) begin
            low_cnt <= 11'h000;
        end else if (low_cnt != 11'h7FF) begin
            low_cnt <= low_cnt + 11'h001;
        end
    end
    AST_ACK_PULSE: assert property (@(posedge cfg_bus_clock) disable iff (!rst_n || cfg_bus_reset)
        cfg_bus_acknowledge |=> !cfg_bus_acknowledge) else $error("ack longer than one bus cycle");
    AST_ACK_CAUSE: assert property (@(posedge cfg_bus_clock) disable iff (!rst_n || cfg_bus_reset)
        $rose(cfg_bus_acknowledge) |-> $past(cfg_bus_strobe)) else $error("ack without strobe");
    AST_ACK_BOUND: assert property (@(posedge cfg_bus_clock) disable iff (!rst_n || cfg_bus_reset)
        $rose(cfg_bus_strobe) |-> ##[1:3] cfg_bus_acknowledge) else $error("strobe not acknowledged");
    AST_REQ_HOLD: assert property (@(posedge cfg_bus_clock) disable iff (!rst_n || cfg_bus_reset)
        $rose(cfg_bus_strobe) |=> cfg_bus_strobe && $stable(cfg_bus_address) && $stable(cfg_bus_write_data)
        && $stable(cfg_bus_write_enable)) else $error("request changed before ack");
    AST_LOCK_STANDBY: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(standby_power_down) |-> ##[1:2] !lock) else $error("lock kept in standby");
    AST_LOCK_RESET: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(loop_reset || loop_reset_with_input_divider) |-> ##[1:2] !lock) else $error("lock kept in reset");
    AST_LOCK_TIME: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(lock) |-> low_cnt >= 11'(LOCK_CYCLES - 2)) else $error("lock back before lock time");
    AST_STEP_FB: assert property (@(posedge clk) disable iff (!rst_n)
        $changed(phase_step_toggle) && phase_output_select == 2'h0 && !phase_control_source
        |-> ##[1:3] !lock) else $error("lock kept after feedback step");
    AST_SRC_BUS: assert property (@(posedge clk) disable iff (!rst_n)
        $changed(phase_control_source) |-> cfg_bus_acknowledge || $past(cfg_bus_acknowledge))
        else $error("source changed without bus write");
endmodule

// ===== verification/tb_top.sv
// testbench: both ends joined, software port driven by tasks
`timescale 1ns/10ps
module tb_top
    import pdc_pkg::*;
;
    logic       clk;
    logic       rst_n;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic [7:0] rdata;
    logic [7:0] v;
    logic       tgl;
    logic [7:0] drop [3] = '{8'h08, 8'h10, 8'h20};
    int         bad_count;
    int         checks;
    // ****************************************
    // ends, checker and tasks
    // ****************************************
    pdc_if pif ();
    pdc_device pdc_device_i (.clk(clk), .rst_n(rst_n), .pins(pif.device));
    pdc_user pdc_user_i (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .pins(pif.user));
    pdc_properties pdc_properties_i (.clk(clk), .rst_n(rst_n), .phase_output_select(pif.phase_output_select),
        .phase_step_toggle(pif.phase_step_toggle), .phase_control_source(pif.phase_control_source),
        .lock(pif.lock), .standby_power_down(pif.standby_power_down), .loop_reset(pif.loop_reset),
        .loop_reset_with_input_divider(pif.loop_reset_with_input_divider), .cfg_bus_clock(pif.cfg_bus_clock),
        .cfg_bus_reset(pif.cfg_bus_reset), .cfg_bus_strobe(pif.cfg_bus_strobe),
        .cfg_bus_write_enable(pif.cfg_bus_write_enable), .cfg_bus_address(pif.cfg_bus_address),
        .cfg_bus_write_data(pif.cfg_bus_write_data), .cfg_bus_acknowledge(pif.cfg_bus_acknowledge));
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic sw_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic sw_rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic bus_op(input logic [7:0] cmd, input logic [4:0] loc, input logic [7:0] d);
        sw_wr(UR_ADDR, {3'h0, loc});
        sw_wr(UR_WDATA, d);
        sw_wr(UR_CMD, cmd);
        v = 8'h04;
        for (int i = 0; i < 50 && v[2]; i++) sw_rd(UR_STATUS, v);
        chk("busy", 8'h00, {5'h00, v[2], 2'h0});
    endtask
    // bounded poll, lock time plus margin
    task automatic wait_lock();
        v = 8'h00;
        for (int i = 0; i < 800 && !v[0]; i++) sw_rd(UR_STATUS, v);
        chk("lock", 8'h01, {7'h00, v[0]});
    endtask
    task automatic step_lock(input logic [7:0] ctrl, input logic [7:0] exp);
        wait_lock();
        sw_wr(UR_CTRL, ctrl);
        tgl = pif.phase_step_toggle;
        sw_wr(UR_CMD, 8'h01);
        // three sync stages in the device plus two in the user end
        repeat (6) @(posedge clk);
        chk("toggle", {7'h00, ~tgl}, {7'h00, pif.phase_step_toggle});
        chk("direction", 8'h01, {7'h00, pif.phase_direction});
        sw_rd(UR_STATUS, v);
        chk("lock after step", exp, {7'h00, v[0]});
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        report_and_stop();
    end
    initial begin
        rst_n = 1'b0;
        addr = 4'h0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        wait_lock();
        $display("test lock_start done");
        bus_op(8'h02, LOC_PHASE, 8'hA5);
        sw_rd(UR_STATUS, v);
        chk("lock after write", 8'h00, {7'h00, v[0]});
        bus_op(8'h04, LOC_PHASE, 8'h00);
        sw_rd(UR_RDATA, v);
        chk("phase readback", 8'hA5, v);
        bus_op(8'h02, LOC_DIV_FB, 8'h5A);
        bus_op(8'h04, LOC_DIV_FB, 8'h00);
        sw_rd(UR_RDATA, v);
        chk("divider readback", 8'h5A, v);
        $display("test bus_rewrite done");
        for (int s = 1; s >= 0; s--) begin
            bus_op(8'h02, LOC_CTRL, 8'(s));
            sw_rd(UR_STATUS, v);
            chk("source", 8'(s), {7'h00, v[1]});
        end
        $display("test phase_source done");
        foreach (drop[k]) begin
            wait_lock();
            sw_wr(UR_CTRL, drop[k]);
            repeat (3) @(posedge clk);
            sw_rd(UR_STATUS, v);
            chk("lock dropped", 8'h00, {7'h00, v[0]});
            sw_wr(UR_CTRL, 8'h00);
        end
        wait_lock();
        sw_wr(UR_CTRL, 8'hC0);
        repeat (3) @(posedge clk);
        sw_rd(UR_STATUS, v);
        chk("lock in divider reset", 8'h01, {7'h00, v[0]});
        sw_wr(UR_CTRL, 8'h00);
        $display("test resets done");
        step_lock(8'h03, 8'h01);
        step_lock(8'h01, 8'h00);
        $display("test phase_step done");
        report_and_stop();
    end
endmodule
